// ==== hdl/pchr_config_header.sv ====
`timescale 1ns/1ps
`include "pchr_cfg_regs.svh"

// Notes on behaviour
// RL1: Manufacturer word at offset 00h is read-only; writes are ignored.
// RL2: Part word at offset 02h is read-only; writes leave it unchanged.
// RL3: Control bits 15 to 10 always read zero regardless of writes.
// RL4: Fast back-to-back enable, control bit 9, reads zero always.
// RL5: Control bit 8 writable; when set, system error driver may assert.
// RL6: Stepping control, control bit 7, hardwired to zero.
// RL7: Control bit 6 writable; parity errors reported only while set.
// RL8: Palette snoop enable, control bit 5, always reads zero.
// RL9: Control bit 4 writable; set permits write-and-invalidate, else plain writes.
// RL10: Special cycle enable, bit 3, reads zero; special cycles ignored.
// RL11: Control bit 2 writable; initiator cycles only while set.
// RL12: Control bit 1 writable; memory cycles claimed only while set.
// RL13: Port space enable, control bit 0, always reads zero.
// RL14: Flags reset with bits 9 and 4 set; event bits 15-11 and 8.
// RL15: Flag bit 15 sets on any address or data parity error.
// RL16: Event flags hold until host writes one there; zero writes ignored.
module pchr_config_header #(
  parameter logic [15:0] MANUF_CODE = 16'h5a5a,  // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0001   // Arbitrary value
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire pchr_pkg::pchr_cfg_req_s cfgReq,
  output logic                        cfgAck,
  output logic [31:0]                 cfgRdData,
  input  wire pchr_pkg::pchr_events_s busEvents,
  input  wire logic                   parityReportReq,
  input  wire logic                   initiatorReq,
  input  wire logic                   memCycleHit,
  output logic                        systemErrorDrive,
  output logic                        parityReportDrive,
  output logic                        initiatorGo,
  output logic                        memCycleClaim,
  output logic                        writeInvalidateAllow
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] ctrlReg;
  logic [15:0] flagsReg;
  logic [15:0] flagsSet;
  logic [15:0] flagsClr;
  logic        ctrlWr;
  logic [15:0] ctrlRead;

  // Mask split per byte lane so no lane write drops bits
  localparam logic [15:0] CtlMask = `PCHR_CTL_WR_MASK;

  assign ctrlWr = cfgReq.sel && cfgReq.write && (cfgReq.index == `PCHR_IDX_CTRL_FLAGS);

  // Only writable cells exist; hardwired bits fall out of the mask
  assign ctrlRead = ctrlReg & `PCHR_CTL_WR_MASK; // see RL3 see RL4 see RL6 see RL8

  // ----------------------------------------
  // Control word
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrlReg <= `PCHR_CTL_RESET;
    end else if (ctrlWr) begin
      // Bits 3 and 0 never stored, so special cycles and port space stay off
      if (cfgReq.byteEn[0]) begin
        ctrlReg[7:0] <= cfgReq.wrData[7:0] & CtlMask[7:0]; // see RL10 see RL13
      end
      if (cfgReq.byteEn[1]) begin
        ctrlReg[15:8] <= cfgReq.wrData[15:8] & CtlMask[15:8]; // see RL3
      end
    end
  end

  // ----------------------------------------
  // Flag word
  // ----------------------------------------
  always_comb begin
    flagsSet = 16'h0000;
    flagsSet[`PCHR_FLG_PARITY_SEEN] = busEvents.addrParityErr
                                    | busEvents.dataParityErr; // see RL15
    flagsSet[`PCHR_FLG_SIG_SYSERR]  = busEvents.sigSystemErr;
    flagsSet[`PCHR_FLG_RCV_MABORT]  = busEvents.rcvMasterAbort;
    flagsSet[`PCHR_FLG_RCV_TABORT]  = busEvents.rcvTargetAbort;
    flagsSet[`PCHR_FLG_SIG_TABORT]  = busEvents.sigTargetAbort;
    flagsSet[`PCHR_FLG_MST_PARITY]  = busEvents.masterParityErr;
  end

  always_comb begin
    flagsClr = 16'h0000;
    if (ctrlWr) begin
      flagsClr = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}}}
               & cfgReq.wrData[31:16] & `PCHR_FLG_EVENT_MASK; // see RL16
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flagsReg <= `PCHR_FLG_RESET; // see RL14
    end else begin
      // A new event beats a clear in the same cycle
      flagsReg <= (flagsReg & ~flagsClr) | (flagsSet & `PCHR_FLG_EVENT_MASK); // see RL16
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfgAck    <= 1'b0;
      cfgRdData <= 32'h0000_0000;
    end else begin
      cfgAck    <= cfgReq.sel;
      cfgRdData <= 32'h0000_0000;
      if (cfgReq.sel && !cfgReq.write) begin
        unique case (cfgReq.index)
          `PCHR_IDX_IDENT:      cfgRdData <= {PART_CODE, MANUF_CODE}; // see RL1 see RL2
          `PCHR_IDX_CTRL_FLAGS: cfgRdData <= {flagsReg, ctrlRead};
          default:              cfgRdData <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Bus-side enables
  // ----------------------------------------
  // Registered so every output comes from a flop; costs one cycle of latency
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      systemErrorDrive  <= 1'b0;
      parityReportDrive <= 1'b0;
    end else begin
      systemErrorDrive  <= busEvents.addrParityErr & ctrlReg[`PCHR_CTL_SYSERR]; // see RL5
      parityReportDrive <= parityReportReq & ctrlReg[`PCHR_CTL_PARITY_RPT]; // see RL7
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      initiatorGo          <= 1'b0;
      memCycleClaim        <= 1'b0;
      writeInvalidateAllow <= 1'b0;
    end else begin
      initiatorGo          <= initiatorReq & ctrlReg[`PCHR_CTL_INITIATOR]; // see RL11
      memCycleClaim        <= memCycleHit & ctrlReg[`PCHR_CTL_MEM_SPACE]; // see RL12
      writeInvalidateAllow <= ctrlReg[`PCHR_CTL_WR_INVAL]; // see RL9
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence identRead;
    cfgReq.sel && !cfgReq.write && cfgReq.index == `PCHR_IDX_IDENT;
  endsequence

  sequence ctrlReadSeq;
    cfgReq.sel && !cfgReq.write && cfgReq.index == `PCHR_IDX_CTRL_FLAGS;
  endsequence

  AST_MANUF_RO: assert property (identRead |=> cfgAck && cfgRdData[15:0] == MANUF_CODE) // see RL1
    else $error("manufacturer word wrong");
  AST_PART_RO: assert property (identRead |=> cfgRdData[31:16] == PART_CODE) // see RL2
    else $error("part word wrong");
  AST_CTRL_HIGH_ZERO: assert property (ctrlReadSeq |=> cfgRdData[15:10] == 6'h00) // see RL3
    else $error("reserved control bits not zero");
  AST_FAST_B2B_ZERO: assert property (ctrlReadSeq |=> !cfgRdData[9]) // see RL4
    else $error("fast back-to-back bit set");
  AST_SYSERR_GATE: assert property (systemErrorDrive |-> $past(ctrlReg[8])) // see RL5
    else $error("system error driven while disabled");
  AST_STAGGER_ZERO: assert property (ctrlReadSeq |=> !cfgRdData[7]) // see RL6
    else $error("stepping bit set");
  AST_PARITY_GATE: assert property (
      parityReportReq && !ctrlReg[6] |=> !parityReportDrive) // see RL7
    else $error("parity reported while disabled");
  AST_PALETTE_ZERO: assert property (ctrlReadSeq |=> !cfgRdData[5]) // see RL8
    else $error("palette snoop bit set");
  AST_WR_INVAL: assert property (
      ctrlWr && cfgReq.byteEn[0] |=> ##1 writeInvalidateAllow == $past(cfgReq.wrData[4], 2)) // see RL9
    else $error("write-invalidate enable not following write");
  AST_SPECIAL_ZERO: assert property (ctrlReadSeq |=> !cfgRdData[3]) // see RL10
    else $error("special cycle bit set");
  AST_INITIATOR_GATE: assert property (
      initiatorReq && !ctrlReg[2] |=> !initiatorGo) // see RL11
    else $error("initiator cycle while disabled");
  AST_MEM_CLAIM: assert property (
      memCycleHit |=> memCycleClaim == $past(ctrlReg[1])) // see RL12
    else $error("memory claim wrong");
  AST_PORT_ZERO: assert property (ctrlReadSeq |=> !cfgRdData[0]) // see RL13
    else $error("port space bit set");
  AST_FLAG_RESET: assert property (
      @(posedge clock) disable iff (1'b0)
      $past(sys_rst) |-> flagsReg == 16'h0210) // see RL14
    else $error("flag word reset value wrong");
  AST_FLAG_RO_BITS: assert property (flagsReg[9] && flagsReg[4] && flagsReg[10] == 1'b0) // see RL14
    else $error("read-only flag bits changed");
  AST_PARITY_SEEN: assert property (
      busEvents.addrParityErr || busEvents.dataParityErr |=> flagsReg[15]) // see RL15
    else $error("parity flag not set");
  AST_FLAG_HOLD: assert property (
      flagsReg[15] && !(ctrlWr && cfgReq.byteEn[3] && cfgReq.wrData[31]) |=> flagsReg[15]) // see RL16
    else $error("parity flag lost without clear");
  AST_FLAG_CLEAR: assert property (
      flagsReg[13] && ctrlWr && cfgReq.byteEn[3] && cfgReq.wrData[29]
      && !busEvents.rcvMasterAbort |=> !flagsReg[13]) // see RL16
    else $error("flag not cleared by one");

  // ----------------------------------------
  // Further checks
  // ----------------------------------------
  sequence anyAccess;
    cfgReq.sel;
  endsequence

  sequence ctrlWriteLow;
    ctrlWr && cfgReq.byteEn[0];
  endsequence

  sequence ctrlWriteHigh;
    ctrlWr && cfgReq.byteEn[1];
  endsequence

  AST_ACK_PULSE: assert property ( // see RL1
      anyAccess |=> cfgAck)
    else $error("access not acknowledged");

  AST_ACK_IDLE: assert property ( // see RL1
      !cfgReq.sel |=> !cfgAck)
    else $error("acknowledge without access");

  AST_WRITE_RDATA_ZERO: assert property ( // see RL2
      cfgReq.sel && cfgReq.write |=> cfgRdData == 32'h0000_0000)
    else $error("read data on a write");

  AST_IDLE_RDATA_ZERO: assert property ( // see RL2
      !cfgReq.sel |=> cfgRdData == 32'h0000_0000)
    else $error("read data while idle");

  AST_UNMAPPED_ZERO: assert property ( // see RL3
      cfgReq.sel && !cfgReq.write && cfgReq.index > 6'h01 |=> cfgRdData == 32'h0000_0000)
    else $error("unmapped index not zero");

  AST_CTRL_FIXED_ZERO: assert property ( // see RL3
      ctrlReg[15:9] == 7'h00 && !ctrlReg[7] && !ctrlReg[5] && !ctrlReg[3] && !ctrlReg[0])
    else $error("hardwired control bit stored");

  AST_CTRL_HOLD: assert property ( // see RL5
      !ctrlWr |=> $stable(ctrlReg))
    else $error("control word changed without write");

  AST_SYSERR_STORE: assert property ( // see RL5
      ctrlWriteHigh |=> ctrlReg[8] == $past(cfgReq.wrData[8]))
    else $error("system error enable not stored");

  AST_PARITY_STORE: assert property ( // see RL7
      ctrlWriteLow |=> ctrlReg[6] == $past(cfgReq.wrData[6]))
    else $error("parity enable not stored");

  AST_WR_INVAL_STORE: assert property ( // see RL9
      ctrlWriteLow |=> ctrlReg[4] == $past(cfgReq.wrData[4]))
    else $error("write-invalidate enable not stored");

  AST_INITIATOR_STORE: assert property ( // see RL11
      ctrlWriteLow |=> ctrlReg[2] == $past(cfgReq.wrData[2]))
    else $error("initiator enable not stored");

  AST_MEM_STORE: assert property ( // see RL12
      ctrlWriteLow |=> ctrlReg[1] == $past(cfgReq.wrData[1]))
    else $error("memory enable not stored");

  AST_SYSERR_FOLLOW: assert property ( // see RL5
      busEvents.addrParityErr && ctrlReg[8] |=> systemErrorDrive)
    else $error("system error not driven");

  AST_PARITY_FOLLOW: assert property ( // see RL7
      parityReportReq && ctrlReg[6] |=> parityReportDrive)
    else $error("parity report not driven");

  AST_INITIATOR_FOLLOW: assert property ( // see RL11
      initiatorReq && ctrlReg[2] |=> initiatorGo)
    else $error("initiator cycle not started");

  AST_MEM_GATE: assert property ( // see RL12
      !ctrlReg[1] |=> !memCycleClaim)
    else $error("memory cycle claimed while disabled");

  AST_WR_INVAL_GATE: assert property ( // see RL9
      !ctrlReg[4] |=> !writeInvalidateAllow)
    else $error("write-invalidate allowed while disabled");

  AST_FLAG_LOW_ZERO: assert property ( // see RL14
      flagsReg[7:5] == 3'h0 && flagsReg[3:0] == 4'h0)
    else $error("read-only flag bit set");

  AST_SIGSYS_SET: assert property ( // see RL14
      busEvents.sigSystemErr |=> flagsReg[14])
    else $error("signalled system error flag not set");

  AST_MABORT_SET: assert property ( // see RL14
      busEvents.rcvMasterAbort |=> flagsReg[13])
    else $error("master abort flag not set");

  AST_TABORT_SET: assert property ( // see RL14
      busEvents.rcvTargetAbort |=> flagsReg[12])
    else $error("target abort flag not set");

  AST_SIG_TABORT_SET: assert property ( // see RL14
      busEvents.sigTargetAbort |=> flagsReg[11])
    else $error("signalled target abort flag not set");

  AST_MST_PARITY_SET: assert property ( // see RL14
      busEvents.masterParityErr |=> flagsReg[8])
    else $error("master parity flag not set");

  AST_PARITY_QUIET: assert property ( // see RL15
      !flagsReg[15] && !busEvents.addrParityErr && !busEvents.dataParityErr |=> !flagsReg[15])
    else $error("parity flag set without error");

endmodule

// ==== hdl/pchr_cfg_regs.svh ====
`ifndef PCHR_CFG_REGS_SVH
`define PCHR_CFG_REGS_SVH

// ----------------------------------------
// Configuration dword indexes
// ----------------------------------------
`define PCHR_IDX_IDENT        6'h00
`define PCHR_IDX_CTRL_FLAGS   6'h01

// ----------------------------------------
// Byte offsets of the 16-bit words
// ----------------------------------------
`define PCHR_OFS_MANUF        8'h00
`define PCHR_OFS_PART         8'h02
`define PCHR_OFS_CTRL         8'h04
`define PCHR_OFS_FLAGS        8'h06

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PCHR_CTL_PORT_SPACE   0
`define PCHR_CTL_MEM_SPACE    1
`define PCHR_CTL_INITIATOR    2
`define PCHR_CTL_SPECIAL      3
`define PCHR_CTL_WR_INVAL     4
`define PCHR_CTL_PALETTE      5
`define PCHR_CTL_PARITY_RPT   6
`define PCHR_CTL_STAGGER      7
`define PCHR_CTL_SYSERR       8
`define PCHR_CTL_FAST_B2B     9
`define PCHR_CTL_WR_MASK      16'h0156
`define PCHR_CTL_RESET        16'h0000

// ----------------------------------------
// Flag field positions and reset
// ----------------------------------------
`define PCHR_FLG_PARITY_SEEN  15
`define PCHR_FLG_SIG_SYSERR   14
`define PCHR_FLG_RCV_MABORT   13
`define PCHR_FLG_RCV_TABORT   12
`define PCHR_FLG_SIG_TABORT   11
`define PCHR_FLG_MST_PARITY   8
`define PCHR_FLG_EVENT_MASK   16'hf900
`define PCHR_FLG_RESET        16'h0210

`endif

// ==== hdl/pchr_pkg.sv ====
package pchr_pkg;

  // ----------------------------------------
  // Bus events that feed the flag word
  // ----------------------------------------
  typedef struct packed {
    logic addrParityErr;
    logic dataParityErr;
    logic sigSystemErr;
    logic rcvMasterAbort;
    logic rcvTargetAbort;
    logic sigTargetAbort;
    logic masterParityErr;
  } pchr_events_s;

  // ----------------------------------------
  // Configuration access request
  // ----------------------------------------
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [5:0]  index;
    logic [3:0]  byteEn;
    logic [31:0] wrData;
  } pchr_cfg_req_s;

endpackage

// ==== tb/pchr_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Host side issuing configuration cycles
// ----------------------------------------
module pchr_host_model (
  input  wire logic                 clock,
  output pchr_pkg::pchr_cfg_req_s   cfgReq,
  input  wire logic                 cfgAck,
  input  wire logic [31:0]          cfgRdData
);
  initial cfgReq = '0;

  // Strobe is held for the taking edge only; answer read one cycle later
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                      input logic [31:0] wd, output logic ack, output logic [31:0] rd);
    @(posedge clock);
    #2;
    cfgReq = {1'b1, wr, idx, be, wd};
    @(posedge clock);
    #2;
    // Stale data would hide a missed strobe
    cfgReq = {1'b0, wr, idx, be, ~wd};
    ack = cfgAck;
    rd = cfgRdData;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  localparam logic [15:0] MANUF = 16'h3c3c;  // Arbitrary value
  localparam logic [15:0] PART  = 16'h0777;  // Arbitrary value
  logic                    clock = 1'b0;
  logic                    sys_rst = 1'b1;
  pchr_pkg::pchr_cfg_req_s cfgReq;
  pchr_pkg::pchr_events_s  busEvents = '0;
  logic                    parityReportReq = 1'b0;
  logic                    initiatorReq = 1'b0;
  logic                    memCycleHit = 1'b0;
  logic                    cfgAck;
  logic [31:0]             cfgRdData;
  logic                    systemErrorDrive;
  logic                    parityReportDrive;
  logic                    initiatorGo;
  logic                    memCycleClaim;
  logic                    writeInvalidateAllow;
  int                      error_cnt = 0;
  int                      samples_checked = 0;
  logic [15:0] evMask [7] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800,
                              16'h0100};
  logic [15:0] ctlSet [7] = '{16'hffff, 16'h0002, 16'h0004, 16'h0010, 16'h0040, 16'h0100,
                              16'h0000};

  always #12.5 clock = ~clock;

  pchr_config_header #(.MANUF_CODE(MANUF), .PART_CODE(PART)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .cfgReq(cfgReq), .cfgAck(cfgAck),
    .cfgRdData(cfgRdData), .busEvents(busEvents), .parityReportReq(parityReportReq),
    .initiatorReq(initiatorReq), .memCycleHit(memCycleHit),
    .systemErrorDrive(systemErrorDrive), .parityReportDrive(parityReportDrive),
    .initiatorGo(initiatorGo), .memCycleClaim(memCycleClaim),
    .writeInvalidateAllow(writeInvalidateAllow));

  pchr_host_model host_u (.clock(clock), .cfgReq(cfgReq), .cfgAck(cfgAck),
                          .cfgRdData(cfgRdData));

  // ----------------------------------------
  // Shared checks and accesses
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // For reads d is the expected word
  task automatic acc(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                     input logic [31:0] d);
    logic        a;
    logic [31:0] r;
    host_u.xfer(wr, idx, be, d, a, r);
    chk("cfgAck", 32'h1, {31'h0, a});
    if (!wr) chk("cfgRdData", d, r);
  endtask

  // Control word then bus-side gating, one cycle of latency
  task automatic enables(input logic [15:0] ctl);
    acc(1'b1, 6'h01, 4'h3, {16'h0, ctl});
    acc(1'b0, 6'h01, 4'hf, {16'h0210, ctl & 16'h0156});
    {parityReportReq, initiatorReq, memCycleHit} = 3'b111;
    busEvents.addrParityErr = 1'b1;
    @(posedge clock);
    #2;
    chk("drives", {27'h0, ctl[8], ctl[6], ctl[2], ctl[1], ctl[4]},
        {27'h0, systemErrorDrive, parityReportDrive, initiatorGo, memCycleClaim,
         writeInvalidateAllow});
    busEvents = '0;
    {parityReportReq, initiatorReq, memCycleHit} = 3'b000;
    acc(1'b1, 6'h01, 4'hc, 32'hffff_0000);
  endtask

  task automatic test_done;
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    acc(1'b0, 6'h00, 4'hf, {PART, MANUF});
    acc(1'b0, 6'h01, 4'hf, 32'h0210_0000);
    acc(1'b1, 6'h00, 4'hf, 32'h0000_0000);
    acc(1'b0, 6'h00, 4'hf, {PART, MANUF});
    acc(1'b1, 6'h02, 4'hf, 32'hffff_ffff);
    acc(1'b0, 6'h02, 4'hf, 32'h0000_0000);
    // Memory claim is checked for every control value, with bit 1 both set and clear
    for (int i = 0; i < 7; i++) begin
      enables(ctlSet[i]);
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      #2;
      busEvents = pchr_pkg::pchr_events_s'(7'h40 >> i);
      @(posedge clock);
      #2;
      busEvents = '0;
      acc(1'b0, 6'h01, 4'hf, {evMask[i] | 16'h0210, 16'h0});
      acc(1'b1, 6'h01, 4'hc, 32'h0000_0000);
      acc(1'b0, 6'h01, 4'hf, {evMask[i] | 16'h0210, 16'h0});
      acc(1'b1, 6'h01, 4'hc, 32'hffff_0000);
      acc(1'b0, 6'h01, 4'hf, 32'h0210_0000);
    end
    test_done;
  end

  initial begin
    #(25 * 3000);
    error_cnt++;
    test_done;
  end
endmodule
